// >>> hdl/sbst_pkg.sv
package sbst_pkg;

   localparam int INSN_W = 3;
   typedef logic [INSN_W-1:0] sbst_insn_t;

   localparam sbst_insn_t INSN_EXTEST   = 3'h0;
   localparam sbst_insn_t INSN_IDCODE   = 3'h1;
   localparam sbst_insn_t INSN_SAMPLE_Z = 3'h2;
   localparam sbst_insn_t INSN_SAMPLE   = 3'h4;
   localparam sbst_insn_t INSN_BYPASS   = 3'h7;

   localparam int ID_W           = 32;
   localparam int BSR_LEN        = 129;
   localparam int BSR_DRV_EN_BIT = 128;
   localparam int BSR_OUT_LSB    = 0;

   localparam logic ID_START_BIT   = 1'h1;
   localparam logic BYPASS_CAPTURE = 1'h0;
   localparam logic DRV_EN_CAPTURE = 1'h1;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DATA, ST_CAP_DATA, ST_SHIFT_DATA, ST_EXIT1_DATA,
      ST_PAUSE_DATA, ST_EXIT2_DATA, ST_UPD_DATA,
      ST_SEL_INSN, ST_CAP_INSN, ST_SHIFT_INSN, ST_EXIT1_INSN,
      ST_PAUSE_INSN, ST_EXIT2_INSN, ST_UPD_INSN
   } sbst_state_t;

endpackage

// >>> hdl/sbst_sync.sv
`timescale 1ns/1ps
module sbst_sync
   import sbst_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clk, // destination clock
   input  wire logic         rst, // synchronous clear
   input  wire logic [W-1:0] d,   // foreign-domain level
   output logic      [W-1:0] q    // synchronised level
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] hold;
   } sbst_sync_t;

   sbst_sync_t s_r;
   sbst_sync_t s_nxt;

   always_comb
   begin
      s_nxt.meta = rst ? '0 : d;
      s_nxt.hold = rst ? '0 : s_r.meta;
   end

   always_ff @(posedge clk)
   begin
      s_r <= s_nxt;
   end

   assign q = s_r.hold;
endmodule // sbst_sync

// >>> hdl/sbst_tap.sv
`timescale 1ns/1ps
// Summary of operation
// - state advances on rising test clock, steered by mode select
// - sixteen-state controller governs registers and instructions
// - power-up enters reset without test clock
// - five high mode-select samples force reset
// - serial input used only in shift states
// - serial output enabled only in shift states
// - shift on rising edge, output on falling
// - instruction preset to IDCODE at reset, capture
// - new instruction takes effect at instruction update
// - three-bit codes: EXTEST, IDCODE, high-Z sample
// - boundary captures ring, shifts under EXTEST, SAMPLE, high-Z sample
// - EXTEST drives output cells, changed at update
// - termination off under EXTEST or high-Z sample
// - high-Z sample floats read data drivers
// - IDCODE captures fixed identification value, shifts it
// - other instructions leave memory operation untouched
// - identification 32 bits, bit 0 one, LSB out
// - BYPASS captures zero into one-bit register
// - SAMPLE captures boundary; reserved codes bypass
// - 129-bit boundary; top cell enables data drivers
module sbst_tap
   import sbst_pkg::*;
#(
   parameter int         DQ_W    = 36,          // read data width
   parameter logic [30:0] ID_UPPER = 31'h0A5C3E1 // arbitrary identification bits
)(
   input  wire logic             CLK,               // core clock
   input  wire logic             SRST,              // synchronous reset
   input  wire logic             TCK,               // test clock
   input  wire logic             TMS,               // mode select
   input  wire logic             TDI,               // serial data in
   output logic                  TDO,               // serial data out
   output logic                  TDO_OE,            // serial output enable
   input  wire logic [BSR_LEN-2:0] IO_RING,         // pad levels for capture
   input  wire logic [DQ_W-1:0]  FUNC_Q,            // functional read data
   input  wire logic             FUNC_Q_OE,         // functional driver enable
   input  wire logic             FUNC_VALID,        // functional data valid
   input  wire logic             FUNC_ECHO_CLK,     // functional echo clock
   input  wire logic             FUNC_ECHO_CLK_N,   // functional echo clock inverse
   input  wire logic             ODT_REQ,           // functional termination enable
   output logic [DQ_W-1:0]       Q_OUT,             // read data pins
   output logic                  Q_OE,              // read data driver enable
   output logic                  READ_VALID_OUT,    // data valid pin
   output logic                  ECHO_CLOCK_OUT,    // echo clock pin
   output logic                  ECHO_CLOCK_N_OUT,  // echo clock inverse pin
   output logic                  ON_DIE_TERMINATION // termination enable
);
   localparam int OUT_W  = DQ_W + 3;
   localparam int HOLD_W = OUT_W + 3;
   localparam int VLD_B  = DQ_W;
   localparam int ECK_B  = DQ_W + 1;
   localparam int ECKN_B = DQ_W + 2;

   typedef struct packed {
      sbst_insn_t           instruction_shift_reg;
      sbst_insn_t           insn_active;
      logic [ID_W-1:0]      id_shift;
      logic                 bypass;
      logic [BSR_LEN-1:0]   bsr_shift;
      logic [OUT_W-1:0]     upd_out;
      logic                 upd_drv_en;
      logic                 hold_tgl;
   } sbst_tck_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } sbst_fall_t;

   typedef struct packed {
      logic             tap_rst;
      logic             tgl_seen;
      logic             extest;
      logic             highz;
      logic             drv_en;
      logic [OUT_W-1:0] upd;
      logic [DQ_W-1:0]  q;
      logic             q_oe;
      logic             valid;
      logic             eck;
      logic             eckn;
      logic             on_die_termination;
   } sbst_clk_t;

   sbst_tck_t            t_r;
   sbst_tck_t            t_nxt;
   sbst_fall_t           f_r;
   sbst_fall_t           f_nxt;
   sbst_clk_t            c_r;
   sbst_clk_t            c_nxt;
   sbst_state_t          state;
   logic [BSR_LEN-2:0]   ring_s;
   logic                 tgl_s;
   logic                 sel_bsr;
   logic                 sel_id;
   logic                 sel_byp;
   logic                 shifting;
   logic [HOLD_W-1:0]    tck_word;

   function automatic logic [HOLD_W-1:0] hold_word(input sbst_tck_t s);
      return {s.insn_active == INSN_EXTEST, s.insn_active == INSN_SAMPLE_Z,
              s.upd_drv_en, s.upd_out};
   endfunction

   sbst_tap_fsm u_fsm (
      .tck   (TCK),
      .rst   (c_r.tap_rst),
      .tms   (TMS),
      .state (state)
   );

   // pads are foreign to the test clock; capture sees them two edges late
   sbst_sync #(.W(BSR_LEN-1)) u_ring_sync (
      .clk (TCK),
      .rst (1'b0),
      .d   (IO_RING),
      .q   (ring_s)
   );

   sbst_sync #(.W(1)) u_tgl_sync (
      .clk (CLK),
      .rst (SRST),
      .d   (t_r.hold_tgl),
      .q   (tgl_s)
   );

   always_comb
   begin
      sel_bsr = (t_r.insn_active == INSN_EXTEST) ||
                (t_r.insn_active == INSN_SAMPLE_Z) ||
                (t_r.insn_active == INSN_SAMPLE);
      sel_id  = (t_r.insn_active == INSN_IDCODE);
      sel_byp = !sel_bsr && !sel_id;
      shifting = (state == ST_SHIFT_DATA) || (state == ST_SHIFT_INSN);
      tck_word = hold_word(t_r);
   end

   // test-clock rising side: capture, shift, update
   always_comb
   begin
      t_nxt = t_r;
      case (state)
         ST_RESET:
         begin
            t_nxt.instruction_shift_reg = INSN_IDCODE;
            t_nxt.insn_active           = INSN_IDCODE;
         end
         ST_CAP_INSN:
            t_nxt.instruction_shift_reg = INSN_IDCODE;
         ST_SHIFT_INSN:
            t_nxt.instruction_shift_reg =
               {TDI, t_r.instruction_shift_reg[INSN_W-1:1]};
         ST_UPD_INSN:
            t_nxt.insn_active = t_r.instruction_shift_reg;
         ST_CAP_DATA:
         begin
            if (sel_bsr)
               t_nxt.bsr_shift = {DRV_EN_CAPTURE, ring_s};
            if (sel_id)
               t_nxt.id_shift = {ID_UPPER, ID_START_BIT};
            if (sel_byp)
               t_nxt.bypass = BYPASS_CAPTURE;
         end
         ST_SHIFT_DATA:
         begin
            if (sel_bsr)
               t_nxt.bsr_shift = {TDI, t_r.bsr_shift[BSR_LEN-1:1]};
            if (sel_id)
               t_nxt.id_shift = {TDI, t_r.id_shift[ID_W-1:1]};
            if (sel_byp)
               t_nxt.bypass = TDI;
         end
         ST_UPD_DATA:
            if (sel_bsr)
            begin
               t_nxt.upd_out    = t_r.bsr_shift[BSR_OUT_LSB +: OUT_W];
               t_nxt.upd_drv_en = t_r.bsr_shift[BSR_DRV_EN_BIT];
            end
         default: ;
      endcase
      // toggle flips on every change of the word; the core side copies the live word when it sees the toggle
      if (hold_word(t_nxt) != tck_word)
         t_nxt.hold_tgl = !t_r.hold_tgl;
   end

   always_ff @(posedge TCK or posedge c_r.tap_rst)
   begin
      if (c_r.tap_rst)
      begin
         t_r                       <= '0;
         t_r.instruction_shift_reg <= INSN_IDCODE;
         t_r.insn_active           <= INSN_IDCODE;
      end
      else
         t_r <= t_nxt;
   end

   // test-clock falling side: serial output
   always_comb
   begin
      f_nxt.tdo_oe = shifting;
      if (state == ST_SHIFT_INSN)
         f_nxt.tdo = t_r.instruction_shift_reg[0];
      else if (sel_bsr)
         f_nxt.tdo = t_r.bsr_shift[0];
      else if (sel_id)
         f_nxt.tdo = t_r.id_shift[0];
      else
         f_nxt.tdo = t_r.bypass;
   end

   always_ff @(negedge TCK or posedge c_r.tap_rst)
   begin
      if (c_r.tap_rst)
         f_r <= '0;
      else
         f_r <= f_nxt;
   end

   assign TDO    = f_r.tdo;
   assign TDO_OE = f_r.tdo_oe;

   // core clock side: pin muxing from the crossed test word
   always_comb
   begin
      c_nxt          = c_r;
      c_nxt.tap_rst  = SRST;
      c_nxt.tgl_seen = tgl_s;
      if (tgl_s != c_r.tgl_seen)
         {c_nxt.extest, c_nxt.highz, c_nxt.drv_en, c_nxt.upd} = tck_word;
      if (c_r.extest)
      begin
         c_nxt.q     = c_r.upd[DQ_W-1:0];
         c_nxt.q_oe  = c_r.drv_en;
         c_nxt.valid = c_r.upd[VLD_B];
         c_nxt.eck   = c_r.upd[ECK_B];
         c_nxt.eckn  = c_r.upd[ECKN_B];
      end
      else
      begin
         c_nxt.q     = FUNC_Q;
         c_nxt.q_oe  = FUNC_Q_OE && !c_r.highz;
         c_nxt.valid = FUNC_VALID;
         c_nxt.eck   = FUNC_ECHO_CLK;
         c_nxt.eckn  = FUNC_ECHO_CLK_N;
      end
      c_nxt.on_die_termination = ODT_REQ && !c_r.extest && !c_r.highz;
      if (SRST)
      begin
         c_nxt         = '0;
         c_nxt.tap_rst = 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      c_r <= c_nxt;
   end

   assign Q_OUT              = c_r.q;
   assign Q_OE               = c_r.q_oe;
   assign READ_VALID_OUT     = c_r.valid;
   assign ECHO_CLOCK_OUT     = c_r.eck;
   assign ECHO_CLOCK_N_OUT   = c_r.eckn;
   assign ON_DIE_TERMINATION = c_r.on_die_termination;

   sequence byp_cap_shift_s;
      (state == ST_CAP_DATA && sel_byp) ##1 (state == ST_SHIFT_DATA);
   endsequence

   sequence id_cap_shift_s;
      (state == ST_CAP_DATA && sel_id) ##1 (state == ST_SHIFT_DATA);
   endsequence

   insn_preset_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      (state == ST_CAP_INSN || state == ST_RESET)
      |=> (t_r.instruction_shift_reg == INSN_IDCODE))
      else $error("instruction not preset to IDCODE");

   insn_update_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      (state == ST_UPD_INSN) |=> (t_r.insn_active == $past(t_r.instruction_shift_reg)))
      else $error("shifted instruction not applied at update");

   insn_hold_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      (state != ST_UPD_INSN && state != ST_RESET) |=> $stable(t_r.insn_active))
      else $error("active instruction changed outside update");

   serial_ignore_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      !shifting && state != ST_CAP_DATA |=> $stable(t_r.bypass) && $stable(t_r.id_shift))
      else $error("data register moved outside shift");

   tdo_enable_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      TDO_OE == shifting)
      else $error("serial output enable outside shift states");

   bypass_zero_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      byp_cap_shift_s |-> (TDO == BYPASS_CAPTURE))
      else $error("bypass capture did not present zero");

   id_start_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      id_cap_shift_s |-> (TDO == ID_START_BIT) && (t_r.id_shift[ID_W-1:1] == ID_UPPER))
      else $error("identification capture wrong");

   bsr_top_a: assert property (@(posedge TCK) disable iff (c_r.tap_rst)
      (state == ST_CAP_DATA && sel_bsr) |=> t_r.bsr_shift[BSR_DRV_EN_BIT])
      else $error("top boundary cell did not capture one");

   highz_float_a: assert property (@(posedge CLK) disable iff (SRST || c_r.tap_rst)
      c_r.highz |=> !Q_OE)
      else $error("read data driven under high-Z sample");

   odt_off_a: assert property (@(posedge CLK) disable iff (SRST || c_r.tap_rst)
      (c_r.extest || c_r.highz) |=> !ON_DIE_TERMINATION)
      else $error("termination left on in test mode");

   extest_drive_a: assert property (@(posedge CLK) disable iff (SRST || c_r.tap_rst)
      c_r.extest |=> (Q_OUT == $past(c_r.upd[DQ_W-1:0])) && (Q_OE == $past(c_r.drv_en)))
      else $error("boundary cells not driving pins");

   // pins still read zero one edge after release, so the lagged reset masks it
   func_pass_a: assert property (@(posedge CLK) disable iff (SRST || c_r.tap_rst)
      !c_r.extest && !c_r.highz |=> (Q_OUT == $past(FUNC_Q)) && (Q_OE == $past(FUNC_Q_OE)))
      else $error("functional path disturbed");
endmodule // sbst_tap

// >>> hdl/sbst_tap_fsm.sv
`timescale 1ns/1ps
module sbst_tap_fsm
   import sbst_pkg::*;
(
   input  wire logic  tck,   // test clock
   input  wire logic  rst,   // asynchronous power-up reset
   input  wire logic  tms,   // mode select
   output sbst_state_t state // current controller state
);
   typedef struct packed {
      sbst_state_t state;
   } sbst_fsm_t;

   sbst_fsm_t f_r;
   sbst_fsm_t f_nxt;

   always_comb
   begin
      f_nxt = f_r;
      unique case (f_r.state)
         ST_RESET:      f_nxt.state = tms ? ST_RESET      : ST_IDLE;
         ST_IDLE:       f_nxt.state = tms ? ST_SEL_DATA   : ST_IDLE;
         ST_SEL_DATA:   f_nxt.state = tms ? ST_SEL_INSN   : ST_CAP_DATA;
         ST_CAP_DATA:   f_nxt.state = tms ? ST_EXIT1_DATA : ST_SHIFT_DATA;
         ST_SHIFT_DATA: f_nxt.state = tms ? ST_EXIT1_DATA : ST_SHIFT_DATA;
         ST_EXIT1_DATA: f_nxt.state = tms ? ST_UPD_DATA   : ST_PAUSE_DATA;
         ST_PAUSE_DATA: f_nxt.state = tms ? ST_EXIT2_DATA : ST_PAUSE_DATA;
         ST_EXIT2_DATA: f_nxt.state = tms ? ST_UPD_DATA   : ST_SHIFT_DATA;
         ST_UPD_DATA:   f_nxt.state = tms ? ST_SEL_DATA   : ST_IDLE;
         ST_SEL_INSN:   f_nxt.state = tms ? ST_RESET      : ST_CAP_INSN;
         ST_CAP_INSN:   f_nxt.state = tms ? ST_EXIT1_INSN : ST_SHIFT_INSN;
         ST_SHIFT_INSN: f_nxt.state = tms ? ST_EXIT1_INSN : ST_SHIFT_INSN;
         ST_EXIT1_INSN: f_nxt.state = tms ? ST_UPD_INSN   : ST_PAUSE_INSN;
         ST_PAUSE_INSN: f_nxt.state = tms ? ST_EXIT2_INSN : ST_PAUSE_INSN;
         ST_EXIT2_INSN: f_nxt.state = tms ? ST_UPD_INSN   : ST_SHIFT_INSN;
         ST_UPD_INSN:   f_nxt.state = tms ? ST_SEL_DATA   : ST_IDLE;
      endcase
   end

   // async so the controller sits in reset before the test clock ever runs
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         f_r.state <= ST_RESET;
      else
         f_r <= f_nxt;
   end

   assign state = f_r.state;

   five_ones_a: assert property (@(posedge tck) disable iff (rst)
      tms [*5] |=> (f_r.state == ST_RESET))
      else $error("five high mode-select samples did not reach reset");

   update_exit_a: assert property (@(posedge tck) disable iff (rst)
      (f_r.state == ST_UPD_DATA || f_r.state == ST_UPD_INSN) && !tms
      |=> (f_r.state == ST_IDLE))
      else $error("update state did not return to idle");
endmodule // sbst_tap_fsm

// >>> verification/sbst_jtag_host.sv
`timescale 1ns/1ps
module sbst_jtag_host (
   output logic      tck,   // test clock, still between frames
   output logic      tms,   // mode select
   output logic      tdi,   // serial data to device
   input  wire logic tdo,   // serial data from device
   input  wire logic tdo_oe // device output enable
);
   initial
   begin
      tck = 1'b0;
      tms <= 1'b1;
      tdi <= 1'b0;
   end
   // one test-clock period; tdo read late in the low phase
   task automatic step(input logic m, input logic d, output logic o, output logic e);
      tms <= m;
      tdi <= d;
      #40;
      // released line reads as inverse so a stray read shows
      o = tdo_oe ? tdo : ~tdo;
      e = tdo_oe;
      tck = 1'b1;
      #40;
      tck = 1'b0;
   endtask
   // data line keeps toggling outside shift so a leak shows
   task automatic idle(input logic m);
      logic o;
      logic e;
      step(m, ~tdi, o, e);
   endtask
endmodule // sbst_jtag_host

// >>> verification/test_sbst_tap.sv
`timescale 1ns/1ps
module test_sbst_tap;
   import sbst_pkg::*;
   localparam logic [30:0] ID_HI = 31'h1234567; // arbitrary value
   logic         CLK, SRST, TCK, TMS, TDI, TDO, TDO_OE;
   logic [127:0] IO_RING;
   logic [35:0]  FUNC_Q, Q_OUT;
   logic         FUNC_Q_OE, FUNC_VALID, FUNC_ECHO_CLK, FUNC_ECHO_CLK_N, ODT_REQ;
   logic         Q_OE, READ_VALID_OUT, ECHO_CLOCK_OUT, ECHO_CLOCK_N_OUT, ON_DIE_TERMINATION;
   logic [128:0] so;
   logic [128:0] pat;
   int           failures = 0;
   int           num_checks = 0;

   sbst_tap #(.DQ_W(36), .ID_UPPER(ID_HI)) sbst_tap_inst (
      .CLK(CLK), .SRST(SRST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
      .TDO_OE(TDO_OE), .IO_RING(IO_RING), .FUNC_Q(FUNC_Q), .FUNC_Q_OE(FUNC_Q_OE),
      .FUNC_VALID(FUNC_VALID), .FUNC_ECHO_CLK(FUNC_ECHO_CLK),
      .FUNC_ECHO_CLK_N(FUNC_ECHO_CLK_N), .ODT_REQ(ODT_REQ), .Q_OUT(Q_OUT),
      .Q_OE(Q_OE), .READ_VALID_OUT(READ_VALID_OUT), .ECHO_CLOCK_OUT(ECHO_CLOCK_OUT),
      .ECHO_CLOCK_N_OUT(ECHO_CLOCK_N_OUT), .ON_DIE_TERMINATION(ON_DIE_TERMINATION));

   sbst_jtag_host sbst_jtag_host_inst (
      .tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO), .tdo_oe(TDO_OE));

   always #2 CLK = ~CLK;

   function automatic bit bad(input bit c);
      num_checks++;
      return c;
   endfunction

   task automatic err(input string m);
      failures++;
      $display("ERROR %0t: %s", $time, m);
   endtask

   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic settle;
      repeat (8) @(posedge CLK);
      #1;
   endtask

   // from Idle through one shift path and back to Idle
   task automatic scan(input bit ir, input int len, input logic [128:0] din,
                       output logic [128:0] dout);
      logic e;
      logic o;
      dout = '0;
      sbst_jtag_host_inst.idle(1'b1);
      if (ir)
         sbst_jtag_host_inst.idle(1'b1);
      sbst_jtag_host_inst.idle(1'b0);
      sbst_jtag_host_inst.idle(1'b0);
      for (int i = 0; i < len; i++)
      begin
         sbst_jtag_host_inst.step(i == len - 1, din[i], o, e);
         dout[i] = o;
         if (bad(e !== 1'b1)) err("tdo off in shift");
      end
      sbst_jtag_host_inst.step(1'b1, 1'b0, o, e);
      if (bad(e !== 1'b0)) err("tdo on after shift");
      sbst_jtag_host_inst.idle(1'b0);
      settle();
   endtask

   task automatic load(input sbst_insn_t c);
      logic [128:0] d;
      scan(1'b1, 3, {126'h0, c}, d);
      if (bad(d[2:0] !== 3'h1)) err("instruction capture not 001");
   endtask

   task automatic func_follows;
      if (bad(Q_OUT !== FUNC_Q || Q_OE !== FUNC_Q_OE)) err("data pins disturbed");
      if (bad(READ_VALID_OUT !== FUNC_VALID)) err("valid pin disturbed");
      if (bad(ON_DIE_TERMINATION !== ODT_REQ)) err("termination disturbed");
      if (bad({ECHO_CLOCK_N_OUT, ECHO_CLOCK_OUT} !== {FUNC_ECHO_CLK_N, FUNC_ECHO_CLK}))
         err("echo pins disturbed");
   endtask

   task automatic t_func;
      @(posedge CLK);
      FUNC_Q          <= 36'h0F0F0F0F0;
      FUNC_Q_OE       <= 1'b0;
      FUNC_VALID      <= 1'b0;
      FUNC_ECHO_CLK   <= 1'b1;
      FUNC_ECHO_CLK_N <= 1'b0;
      ODT_REQ         <= 1'b0;
      settle();
      func_follows();
      @(posedge CLK);
      FUNC_Q_OE       <= 1'b1;
      FUNC_VALID      <= 1'b1;
      FUNC_ECHO_CLK   <= 1'b0;
      FUNC_ECHO_CLK_N <= 1'b1;
      ODT_REQ         <= 1'b1;
      settle();
      func_follows();
   endtask

   task automatic t_reset;
      if (bad(TDO_OE !== 1'b0)) err("tdo enabled after reset");
      func_follows();
      sbst_jtag_host_inst.idle(1'b0);
   endtask

   task automatic t_idcode;
      scan(1'b0, 32, '1, so);
      if (bad(so[31:0] !== {ID_HI, 1'b1})) err("identification mismatch");
      func_follows();
   endtask

   task automatic t_bypass;
      sbst_insn_t codes[4] = '{3'h7, 3'h3, 3'h5, 3'h6};
      foreach (codes[k])
      begin
         load(codes[k]);
         scan(1'b0, 8, 129'hB6, so);
         if (bad(so[7:0] !== 8'h6C)) err("bypass path wrong");
         func_follows();
      end
   endtask

   task automatic t_sample_z;
      load(INSN_SAMPLE_Z);
      if (bad(Q_OE !== 1'b0)) err("read drivers not floated");
      if (bad(ON_DIE_TERMINATION !== 1'b0)) err("termination on");
      scan(1'b0, 129, '0, so);
      if (bad(so[127:0] !== IO_RING)) err("ring capture wrong");
      if (bad(so[128] !== DRV_EN_CAPTURE)) err("driver cell capture wrong");
   endtask

   task automatic t_extest;
      pat = '0;
      pat[35:0] = 36'hA5C3F0E19;
      pat[38:36] = 3'h5;
      pat[128] = 1'b1;
      load(INSN_EXTEST);
      scan(1'b0, 129, pat, so);
      if (bad(so[127:0] !== IO_RING)) err("extest capture wrong");
      if (bad(Q_OUT !== pat[35:0] || Q_OE !== 1'b1)) err("extest data pins");
      if (bad({ECHO_CLOCK_N_OUT, ECHO_CLOCK_OUT, READ_VALID_OUT} !== 3'h5)) err("extest ctl");
      if (bad(ON_DIE_TERMINATION !== 1'b0)) err("termination on in extest");
      @(posedge CLK);
      FUNC_Q <= ~FUNC_Q;
      settle();
      if (bad(Q_OUT !== pat[35:0])) err("extest let core data through");
      pat[128] = 1'b0;
      scan(1'b0, 129, pat, so);
      if (bad(Q_OE !== 1'b0)) err("driver cell ignored");
   endtask

   task automatic t_sample;
      load(INSN_SAMPLE);
      func_follows();
      @(posedge CLK);
      IO_RING <= ~IO_RING;
      scan(1'b0, 129, '0, so);
      if (bad(so[127:0] !== IO_RING)) err("sample capture wrong");
   endtask

   task automatic t_tms_reset;
      load(INSN_SAMPLE_Z);
      repeat (5) sbst_jtag_host_inst.idle(1'b1);
      sbst_jtag_host_inst.idle(1'b0);
      settle();
      func_follows();
      t_idcode();
   endtask

   initial
   begin
      CLK = 1'b0;
      SRST = 1'b1;
      IO_RING = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
      FUNC_Q = 36'h123456789;
      FUNC_Q_OE = 1'b1;
      FUNC_VALID = 1'b1;
      FUNC_ECHO_CLK = 1'b0;
      FUNC_ECHO_CLK_N = 1'b1;
      ODT_REQ = 1'b1;
      repeat (16) @(posedge CLK);
      SRST <= 1'b0;
      FUNC_Q <= 36'h9ABCDEF01;
      settle();
      t_reset();
      t_func();
      t_idcode();
      t_bypass();
      t_sample_z();
      t_extest();
      t_sample();
      t_tms_reset();
      wrap_up();
   end

   initial
   begin
      #300000;
      err("run timed out");
      wrap_up();
   end
endmodule // test_sbst_tap
